// ---- common/pcp_pkg.sv ----
// Shared constants and types for the converter pin control port and its host.
package pcp_pkg;
  // Serial framing.
  localparam int FRAME_BITS = 8;
  localparam int XFER_BITS = 16;
  localparam int CMD_READ_BIT = 7;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_IOPORT = 3'h2;
  // Mode register layout.
  localparam int MODE_CLOCK_OUTPUT_DISABLE_BIT = 3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // I/O port register layout; bits 2..0 are reserved and read as zero.
  localparam int IO_P0_VAL_BIT = 7;
  localparam int IO_P1_VAL_BIT = 6;
  localparam int IO_PORT_ZERO_DIRECTION_BIT = 5;
  localparam int IO_PORT_ONE_DIRECTION_BIT = 4;
  localparam int IO_SYNC_EN_BIT = 3;
  localparam logic [7:0] IOPORT_MASK = 8'hF8;
  localparam logic [7:0] IOPORT_RESET = 8'h30;
  // Timing.
  localparam int MCLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_MIN_NS = 50;
  localparam int SYNC_MIN_NS = 50;
  localparam logic [3:0] SCLK_HALF_CYC =
    4'((SCLK_HALF_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [3:0] SYNC_MIN_CYC =
    4'((SYNC_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  // Host command port map.
  localparam logic [1:0] HOST_XFER = 2'h0;
  localparam logic [1:0] HOST_STATUS = 2'h1;
  localparam logic [1:0] HOST_CFG = 2'h2;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int CFG_3W_BIT = 0;

  typedef enum logic [0:0] {
    PH_CMD = 1'b0,
    PH_DATA = 1'b1
  } pcp_phase_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_LOW = 3'b010,
    HS_HIGH = 3'b011,
    HS_TAIL = 3'b100
  } pcp_host_state_e;
endpackage : pcp_pkg

// ---- common/pcp_if.sv ----
// Serial link between the converter pin control port and its host.
interface pcp_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic miso;

  // The data line idles high when the device does not drive it.
  assign miso = dout_oe ? dout : 1'b1;

  modport dev (
    input sclk,
    input cs_n,
    input din,
    output dout,
    output dout_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output din,
    input miso
  );
endinterface : pcp_if

// ---- verilog/pcp_device.sv ----
// Device end: serial register access, port pins, sync input and clock output.
module pcp_device (
  pcp_if.dev link,
  input wire logic mclk,
  input wire logic nrst,
  input wire logic p0_in,
  output logic p0_out,
  output logic p0_oe,
  input wire logic p1_in,
  output logic p1_out,
  output logic p1_oe,
  output logic master_clock_output,
  output logic single_ended_ref_common,
  output logic modulator_sync_hold,
  output logic modulator_restart
);
  // Serial clock domain.
  logic frame_rst_n;
  logic [2:0] bit_cnt_q;
  pcp_pkg::pcp_phase_e phase_q;
  logic [6:0] shift_q;
  logic [7:0] cmd_q;
  logic [7:0] mode_q;
  logic [7:0] io_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] read_data;
  logic [7:0] tx_q;
  logic p1_ls1_q;
  logic p1_ls2_q;
  // Master clock domain.
  logic [5:0] cfg_s1_q;
  logic [5:0] cfg_s2_q;
  logic clock_output_disable_m;
  logic p0_val_m;
  logic p1_val_m;
  logic port_zero_direction_m;
  logic port_one_direction_m;
  logic sync_en_m;
  logic p1_ms1_q;
  logic p1_ms2_q;
  logic [3:0] sync_cnt_q;
  logic hold_q;
  logic restart_q;
  logic sync_low;

  // Chip select high ends a frame; tied low, the bit counter simply wraps every
  // eight clocks, so the host must never send a partial byte in that mode.
  assign frame_rst_n = nrst & ~link.cs_n;

  assign rx_byte = {shift_q, link.din};
  assign byte_done = (bit_cnt_q == 3'(pcp_pkg::FRAME_BITS - 1));

  // All data moves on edges of the host's serial clock.
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_q <= pcp_pkg::PH_CMD;
    end else if (byte_done) begin
      case (phase_q)
        pcp_pkg::PH_CMD: phase_q <= pcp_pkg::PH_DATA;
        pcp_pkg::PH_DATA: phase_q <= pcp_pkg::PH_CMD;
        default: phase_q <= pcp_pkg::PH_CMD;
      endcase
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_q <= 7'h00;
    end else begin
      shift_q <= rx_byte[6:0];
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cmd_q <= 8'h00;
    end else if (byte_done && phase_q == pcp_pkg::PH_CMD) begin
      cmd_q <= rx_byte;
    end
  end

  // Registers survive chip select going high; only the reset pin clears them.
  always_ff @(posedge link.sclk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= pcp_pkg::MODE_RESET;
      io_q <= pcp_pkg::IOPORT_RESET;
    end else if (byte_done && phase_q == pcp_pkg::PH_DATA &&
                 !cmd_q[pcp_pkg::CMD_READ_BIT]) begin
      case (cmd_q[2:0])
        pcp_pkg::REG_MODE: mode_q <= rx_byte;
        pcp_pkg::REG_IOPORT: io_q <= rx_byte & pcp_pkg::IOPORT_MASK;
        default: begin
        end
      endcase
    end
  end

  // The port-one pin level is read back through two flops of this domain.
  always_ff @(posedge link.sclk or negedge nrst) begin
    if (!nrst) begin
      p1_ls1_q <= 1'b0;
      p1_ls2_q <= 1'b0;
    end else begin
      p1_ls1_q <= p1_in;
      p1_ls2_q <= p1_ls1_q;
    end
  end

  always_comb begin
    case (cmd_q[2:0])
      pcp_pkg::REG_MODE: read_data = mode_q;
      pcp_pkg::REG_IOPORT: begin
        read_data = io_q;
        read_data[pcp_pkg::IO_P1_VAL_BIT] = p1_ls2_q;
      end
      default: read_data = 8'h00;
    endcase
  end

  // Output data changes on falling edges so it is stable at the host's
  // sampling edge; the first falling edge of a read data byte loads it.
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_q <= 8'h00;
    end else if (phase_q == pcp_pkg::PH_DATA && bit_cnt_q == 3'h0 &&
                 cmd_q[pcp_pkg::CMD_READ_BIT]) begin
      tx_q <= read_data;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign link.dout = tx_q[7];
  // The line is released at the rising edge that ends the read byte.
  assign link.dout_oe = (phase_q == pcp_pkg::PH_DATA) &
                        cmd_q[pcp_pkg::CMD_READ_BIT];

  // Configuration bits are quasi-static, so a plain two-flop crossing per bit
  // is enough; a write reaches the clock gate and sync logic one to two master clocks later, the pins two to three.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_s1_q <= {1'b0, pcp_pkg::IOPORT_RESET[7:3]};
      cfg_s2_q <= {1'b0, pcp_pkg::IOPORT_RESET[7:3]};
    end else begin
      cfg_s1_q <= {mode_q[pcp_pkg::MODE_CLOCK_OUTPUT_DISABLE_BIT], io_q[7:3]};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign clock_output_disable_m = cfg_s2_q[5];
  assign p0_val_m = cfg_s2_q[pcp_pkg::IO_P0_VAL_BIT - 3];
  assign p1_val_m = cfg_s2_q[pcp_pkg::IO_P1_VAL_BIT - 3];
  assign port_zero_direction_m = cfg_s2_q[pcp_pkg::IO_PORT_ZERO_DIRECTION_BIT - 3];
  assign port_one_direction_m = cfg_s2_q[pcp_pkg::IO_PORT_ONE_DIRECTION_BIT - 3];
  assign sync_en_m = cfg_s2_q[pcp_pkg::IO_SYNC_EN_BIT - 3];

  // A direction bit of one makes the pin an input.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      p0_out <= 1'b0;
      p0_oe <= 1'b0;
      p1_out <= 1'b0;
      p1_oe <= 1'b0;
      single_ended_ref_common <= 1'b1;
    end else begin
      p0_out <= p0_val_m;
      p0_oe <= ~port_zero_direction_m;
      p1_out <= p1_val_m;
      p1_oe <= ~port_one_direction_m;
      single_ended_ref_common <= port_zero_direction_m;
    end
  end

  // The gate changes only at a rising master edge, when the inverted clock
  // falls, so switching the output off or on cannot cut a pulse short.
  // Reset clears the disable bit, so the clock keeps coming out during reset.
  assign master_clock_output = ~mclk & ~clock_output_disable_m;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      p1_ms1_q <= 1'b0;
      p1_ms2_q <= 1'b0;
    end else begin
      p1_ms1_q <= p1_in;
      p1_ms2_q <= p1_ms1_q;
    end
  end

  // Sync acts only with the enable bit set and the pin an input; a floating
  // pin would give random holds, which is why the far side must drive it.
  assign sync_low = sync_en_m & port_one_direction_m & ~p1_ms2_q;

  // Low pulses shorter than the minimum sync width are treated as noise.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_cnt_q <= 4'h0;
    end else if (!sync_low) begin
      sync_cnt_q <= 4'h0;
    end else if (sync_cnt_q != pcp_pkg::SYNC_MIN_CYC) begin
      sync_cnt_q <= sync_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      hold_q <= sync_low && (sync_cnt_q == pcp_pkg::SYNC_MIN_CYC);
      restart_q <= hold_q && !(sync_low && (sync_cnt_q == pcp_pkg::SYNC_MIN_CYC));
    end
  end

  assign modulator_sync_hold = hold_q;
  assign modulator_restart = restart_q;
endmodule : pcp_device

// ---- verilog/pcp_host.sv ----
// Host end: command port that runs two-byte serial frames to the device.
module pcp_host (
  pcp_if.host link,
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  pcp_pkg::pcp_host_state_e state_q;
  logic [3:0] half_cnt_q;
  logic [4:0] bit_cnt_q;
  logic half_done;
  logic start;
  logic cfg_3w_q;
  logic sclk_q;
  logic cs_n_q;
  logic din_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [7:0] rx_last_q;
  logic miso_s1_q;
  logic miso_s2_q;

  assign half_done = (half_cnt_q == pcp_pkg::SCLK_HALF_CYC - 4'h1);
  assign start = wr && (addr == pcp_pkg::HOST_XFER) && (state_q == pcp_pkg::HS_IDLE);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_3w_q <= 1'b0;
    end else if (wr && addr == pcp_pkg::HOST_CFG) begin
      cfg_3w_q <= wdata[pcp_pkg::CFG_3W_BIT];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= pcp_pkg::HS_IDLE;
      half_cnt_q <= 4'h0;
      bit_cnt_q <= 5'h00;
    end else begin
      half_cnt_q <= (half_done || state_q == pcp_pkg::HS_IDLE) ? 4'h0 : half_cnt_q + 4'h1;
      case (state_q)
        pcp_pkg::HS_IDLE: begin
          bit_cnt_q <= 5'h00;
          if (start) begin
            state_q <= pcp_pkg::HS_LEAD;
          end
        end
        pcp_pkg::HS_LEAD: if (half_done) state_q <= pcp_pkg::HS_LOW;
        pcp_pkg::HS_LOW: if (half_done) state_q <= pcp_pkg::HS_HIGH;
        pcp_pkg::HS_HIGH: begin
          if (half_done) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            state_q <= (bit_cnt_q == 5'(pcp_pkg::XFER_BITS - 1)) ?
                       pcp_pkg::HS_TAIL : pcp_pkg::HS_LOW;
          end
        end
        pcp_pkg::HS_TAIL: if (half_done) state_q <= pcp_pkg::HS_IDLE;
        default: state_q <= pcp_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      miso_s1_q <= 1'b1;
      miso_s2_q <= 1'b1;
    end else begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  // The serial clock is made here by dividing the master clock; it idles high
  // and each half period lasts at least the minimum pulse width.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      din_q <= 1'b0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
    end else begin
      case (state_q)
        pcp_pkg::HS_IDLE: begin
          cs_n_q <= ~(start | cfg_3w_q);
          if (start) begin
            tx_q <= wdata;
          end
        end
        pcp_pkg::HS_LEAD, pcp_pkg::HS_HIGH: begin
          if (half_done && !(state_q == pcp_pkg::HS_HIGH &&
              bit_cnt_q == 5'(pcp_pkg::XFER_BITS - 1))) begin
            sclk_q <= 1'b0;
            din_q <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
          end
        end
        pcp_pkg::HS_LOW: begin
          if (half_done) begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[14:0], miso_s2_q};
          end
        end
        pcp_pkg::HS_TAIL: begin
          if (half_done) begin
            cs_n_q <= ~cfg_3w_q;
          end
        end
        default: sclk_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_last_q <= 8'h00;
    end else if (state_q == pcp_pkg::HS_TAIL && half_done) begin
      rx_last_q <= rx_q[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        pcp_pkg::HOST_STATUS: rdata <= {rx_last_q, 7'h00, state_q != pcp_pkg::HS_IDLE};
        pcp_pkg::HOST_CFG: rdata <= {15'h0000, cfg_3w_q};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din = din_q;
endmodule : pcp_host

// ---- testbench/pcp_link_monitor.sv ----
// Checker for the serial link and the sync pin between the host and device ends.
module pcp_link_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_oe,
  input wire logic p1_in,
  input wire logic p1_oe,
  input wire logic modulator_sync_hold,
  input wire logic modulator_restart
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // A serial clock half is 13 master clocks, so eight is a safe lower bound.
  sequence s_low_half;
    !sclk [*8];
  endsequence

  sequence s_sync_low;
    !$past(p1_in, 3) && !$past(p1_in, 12);
  endsequence

  AST_IDLE_SCLK: assert property (cs_n |-> sclk)
    else $error("Serial clock moved while the device was deselected.");
  AST_OE_SELECT: assert property (dout_oe |-> !cs_n)
    else $error("Device drove data while deselected.");
  AST_CS_FALL: assert property ($fell(cs_n) |-> sclk)
    else $error("Frame started with the serial clock low.");
  AST_LOW_HALF: assert property ($fell(sclk) |-> s_low_half)
    else $error("Serial clock low half too short.");
  AST_DIN_HOLD: assert property ($rose(sclk) |-> $stable(din))
    else $error("Data input changed at the sampling edge.");
  AST_RESTART_AFTER: assert property ($fell(modulator_sync_hold) |-> ##[0:1] modulator_restart)
    else $error("No restart pulse after sync release.");
  AST_RESTART_ONE: assert property (modulator_restart |=> !modulator_restart)
    else $error("Restart pulse longer than one cycle.");
  AST_HOLD_CAUSE: assert property ($rose(modulator_sync_hold) |-> s_sync_low)
    else $error("Sync hold rose without a long low on the pin.");
  AST_HOLD_INPUT: assert property (modulator_sync_hold |-> !p1_oe)
    else $error("Sync hold active while the pin is an output.");
endmodule : pcp_link_monitor

// ---- testbench/test_adc_pin_control_port_logic.sv ----
// Self-checking bench joining the host end and the device end over the serial link.
module test_adc_pin_control_port_logic;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
  logic mclk, nrst, wr, rd, p0_ext, p1_ext, p0_in, p1_in, p0_out, p0_oe, p1_out, p1_oe;
  logic mco, ref_c, hold, restart, found;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, s;
  logic [7:0] q;
  int failures, checked;

  assign p0_in = p0_oe ? p0_out : p0_ext;
  assign p1_in = p1_oe ? p1_out : p1_ext;

  pcp_if link_i ();
  pcp_device pcp_device_i (.link(link_i), .mclk(mclk), .nrst(nrst), .p0_in(p0_in),
    .p0_out(p0_out), .p0_oe(p0_oe), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe),
    .master_clock_output(mco), .single_ended_ref_common(ref_c),
    .modulator_sync_hold(hold), .modulator_restart(restart));
  pcp_host pcp_host_i (.link(link_i), .mclk(mclk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  pcp_link_monitor pcp_link_monitor_i (.mclk(mclk), .nrst(nrst), .sclk(link_i.sclk),
    .cs_n(link_i.cs_n), .din(link_i.din), .dout_oe(link_i.dout_oe), .p1_in(p1_in),
    .p1_oe(p1_oe), .modulator_sync_hold(hold), .modulator_restart(restart));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic hw(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : hw

  task automatic hr(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : hr

  // Polling is bounded so a stuck busy flag ends as a mismatch, not a hang.
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] st;
    hw(pcp_pkg::HOST_XFER, {c, d});
    st = 16'h0001;
    for (int i = 0; i < 1000 && st[0] !== 1'b0; i++) hr(pcp_pkg::HOST_STATUS, st);
    `CHK(st[0], 1'b0);
    r = st[15:8];
  endtask : xfer

  task automatic wr_reg(input logic [2:0] r, input logic [7:0] d);
    logic [7:0] dummy;
    xfer({5'h00, r}, d, dummy);
  endtask : wr_reg

  task automatic chk_reg(input logic [2:0] r, input logic [7:0] e);
    logic [7:0] v;
    xfer({5'h10, r}, 8'h00, v);
    `CHK(v, e);
  endtask : chk_reg

  // Samples the clock output in both halves of one master clock period.
  task automatic chk_mco(input logic on);
    logic v;
    @(posedge mclk);
    #1 v = mco;
    @(negedge mclk);
    #1;
    `CHK({v, mco}, on ? 2'b01 : 2'b00);
  endtask : chk_mco

  task automatic report_and_stop;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    p0_ext = 1'b0;
    p1_ext = 1'b1;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    chk_mco(1'b1);
    `CHK({p0_oe, p1_oe, ref_c, hold, restart}, 5'b00100);
    @(posedge mclk);
    nrst <= 1'b1;
    // Reset value 30 with the port-one bit showing the pin, which is pulled high here.
    chk_reg(pcp_pkg::REG_IOPORT, 8'h70);
    chk_reg(pcp_pkg::REG_MODE, 8'h00);
    wr_reg(pcp_pkg::REG_MODE, 8'h08);
    chk_mco(1'b0);
    wr_reg(pcp_pkg::REG_MODE, 8'h00);
    chk_mco(1'b1);
    wr_reg(pcp_pkg::REG_IOPORT, 8'h87);
    repeat (6) @(posedge mclk);
    #1 `CHK({p0_oe, p0_out, p1_oe, p1_out, ref_c}, 5'b11100);
    chk_reg(pcp_pkg::REG_IOPORT, 8'h80);
    wr_reg(pcp_pkg::REG_IOPORT, 8'h40);
    repeat (6) @(posedge mclk);
    #1 `CHK({p0_oe, p0_out, p1_oe, p1_out}, 4'b1011);
    chk_reg(pcp_pkg::REG_IOPORT, 8'h40);
    wr_reg(pcp_pkg::REG_IOPORT, 8'h10);
    chk_reg(pcp_pkg::REG_IOPORT, 8'h50);
    @(posedge mclk);
    p1_ext <= 1'b0;
    repeat (30) @(posedge mclk);
    #1 `CHK({hold, p1_oe}, 2'b00);
    chk_reg(pcp_pkg::REG_IOPORT, 8'h10);
    @(posedge mclk);
    p1_ext <= 1'b1;
    wr_reg(pcp_pkg::REG_IOPORT, 8'h38);
    repeat (6) @(posedge mclk);
    #1 `CHK({p0_oe, ref_c}, 2'b01);
    @(posedge mclk);
    p1_ext <= 1'b0;
    repeat (8) @(posedge mclk);
    p1_ext <= 1'b1;
    repeat (30) @(posedge mclk);
    #1 `CHK(hold, 1'b0);
    @(posedge mclk);
    p1_ext <= 1'b0;
    repeat (25) @(posedge mclk);
    #1 `CHK(hold, 1'b1);
    @(posedge mclk);
    p1_ext <= 1'b1;
    found = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      #1 found = found | restart;
    end
    `CHK({found, hold}, 2'b10);
    xfer(8'h85, 8'h00, q);
    `CHK(q, 8'h00);
    hr(2'h3, s);
    `CHK(s, 16'h0000);
    hw(pcp_pkg::HOST_CFG, 16'h0001);
    chk_reg(pcp_pkg::REG_IOPORT, 8'h78);
    `CHK(link_i.cs_n, 1'b0);
    hw(pcp_pkg::HOST_CFG, 16'h0000);
    repeat (4) @(posedge mclk);
    #1 `CHK(link_i.cs_n, 1'b1);
    wr_reg(pcp_pkg::REG_MODE, 8'h08);
    @(posedge mclk);
    nrst <= 1'b0;
    chk_mco(1'b1);
    @(posedge mclk);
    nrst <= 1'b1;
    chk_reg(pcp_pkg::REG_IOPORT, 8'h70);
    chk_reg(pcp_pkg::REG_MODE, 8'h00);
    report_and_stop();
  end
endmodule : test_adc_pin_control_port_logic
